// ==== include/ssat_map.vh ====
// Register map, field positions, reset values and timing counts
`ifndef SSAT_MAP_VH
`define SSAT_MAP_VH

// Byte offsets on the register port
`define SSAT_OFF_SAMPLE     4'h0
`define SSAT_OFF_CONTROL    4'h4
`define SSAT_OFF_STATUS     4'h8
`define SSAT_OFF_CAUSE      4'hC

// Field positions
`define SSAT_CTRL_EN_BIT    0
`define SSAT_CTRL_IRQ_BIT   1
`define SSAT_STAT_LOW_BIT   0
`define SSAT_CAUSE_LOW_BIT  0
`define SSAT_LEFT_MSB       31
`define SSAT_LEFT_LSB       16
`define SSAT_RIGHT_MSB      15
`define SSAT_RIGHT_LSB      0

// Reset values
`define SSAT_CTRL_EN_RST    1'h0
`define SSAT_CTRL_IRQ_RST   1'h0
`define SSAT_WORD_RST       32'h0000_0000
`define SSAT_FULL_BE        4'hF

// Sample store sizing
`define SSAT_FIFO_AW        8
`define SSAT_FIFO_FULL      9'h100
`define SSAT_LOW_MARK       9'h080

// Serial timing, counted in audio clock edges
`define SSAT_RATE_A_HZ      44100
`define SSAT_RATE_B_HZ      48000
`define SSAT_AUD_PER_FRAME  256
`define SSAT_DIV_RISE       3'h3
`define SSAT_DIV_LAST       3'h7
`define SSAT_BIT_LAST       5'h1F

`endif

// ==== verilog/ssat_fifo.v ====
`include "ssat_map.vh"
`default_nettype none

module ssat_fifo (
  // Clock, reset, enable
  input  wire        clk_i,
  input  wire        rst_n_i,
  input  wire        ce_i,
  // Filling side
  input  wire        wr_valid_i,
  input  wire [31:0] wr_data_i,
  output wire        wr_ready_o,
  // Draining side
  output wire        rd_valid_o,
  output wire [31:0] rd_data_o,
  input  wire        rd_ready_i,
  // Occupancy
  output wire [8:0]  level_o
);

  reg [31:0]               mem [0:(1 << `SSAT_FIFO_AW) - 1];
  reg [`SSAT_FIFO_AW-1:0]  wr_ptr;
  reg [`SSAT_FIFO_AW-1:0]  rd_ptr;
  reg [8:0]                count;
  wire                     do_wr;
  wire                     do_rd;

  // Handshakes follow the occupancy count directly
  assign wr_ready_o = (count != `SSAT_FIFO_FULL);
  assign rd_valid_o = (count != 9'h000);
  assign rd_data_o  = mem[rd_ptr];
  assign level_o    = count;
  assign do_wr      = wr_valid_i & wr_ready_o;
  assign do_rd      = rd_ready_i & rd_valid_o;

  // Storage needs no reset, only the pointers and count do
  always @(posedge clk_i) begin
    if (ce_i && do_wr) begin
      mem[wr_ptr] <= wr_data_i;
    end
  end

  // Pointers and count; wrap is natural at 256 entries
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wr_ptr <= 8'h00;
      rd_ptr <= 8'h00;
      count  <= 9'h000;
    end else if (ce_i) begin
      if (do_wr) begin
        wr_ptr <= wr_ptr + 8'h01;
      end
      if (do_rd) begin
        rd_ptr <= rd_ptr + 8'h01;
      end
      if (do_wr && !do_rd) begin
        count <= count + 9'h001;
      end else if (do_rd && !do_wr) begin
        count <= count - 9'h001;
      end
    end
  end

endmodule // ssat_fifo

`default_nettype wire

// ==== verilog/ssat_top.v ====
// What this block does
// - Sends 16-bit samples per channel at 44.1 or 48 kHz frame rates.
// - Drives a bit clock and shifts each 16-bit half word one bit per period.
// - Channel select is low during left data, high during right data.
// - Each half word leaves the store most significant bit first.
// - The sample store holds 256 stereo words.
// - Low flag is set whenever fewer than 128 stereo samples are stored.
// - Status read returns the low flag in bit 0.
// - With interrupts enabled, entering the low condition raises a request.
// - Reading the interrupt cause register clears the pending request.
// - Control bit 0 enables the serial output; cleared, nothing is sent.
// - Sample port at 0x00, control at 0x04, status at 0x08.
`include "ssat_map.vh"
`default_nettype none

module ssat_top (
  // Clock, reset, enable
  input  wire        clk_i,
  input  wire        rst_n_i,
  input  wire        ce_i,
  // Register port
  input  wire [3:0]  bus_addr_i,
  input  wire        bus_wr_i,
  input  wire        bus_rd_i,
  input  wire [3:0]  bus_be_i,
  input  wire [31:0] bus_wdata_i,
  output reg  [31:0] bus_rdata_o,
  output reg         bus_rvalid_o,
  // Audio link
  input  wire        aud_clk_i,
  output reg         sck_o,
  output wire        sd_o,
  output reg         channel_select_line_o,
  // Interrupt request
  output reg         irq_o
);

  // Reset release
  reg         rst_q1;
  reg         rst_n;
  // Audio clock sampling
  reg         aud_q1;
  reg         aud_q2;
  reg         aud_q3;
  wire        aud_rise;
  // Control state
  reg         ctrl_en;
  reg         ctrl_irq;
  reg         low_q;
  // Sample store wiring
  wire        st_wr_valid;
  wire        st_rd_valid;
  wire [31:0] st_rd_data;
  wire        st_rd_ready;
  wire [8:0]  st_level;
  wire        fifo_low_status;
  // Serialiser
  reg  [2:0]  div_cnt;
  reg  [4:0]  bit_cnt;
  reg  [31:0] shift;
  reg  [31:0] next_shift;
  wire [4:0]  next_bit;
  wire        bit_end;
  // Cause read strobe and low-entry interrupt event
  wire        rd_cause;
  wire        low_rise;

  // Address match, shared by the write and read paths
  function sel;
    input [3:0] addr;
    input [3:0] off;
    begin
      sel = (addr == off);
    end
  endfunction

  // Reset is asserted at once, released two edges later
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_q1 <= 1'b0;
      rst_n  <= 1'b0;
    end else begin
      rst_q1 <= 1'b1;
      rst_n  <= rst_q1;
    end
  end

  // Audio clock is foreign: two flops, then a third for edge finding
  always @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      aud_q1 <= 1'b0;
      aud_q2 <= 1'b0;
      aud_q3 <= 1'b0;
    end else if (ce_i) begin
      aud_q1 <= aud_clk_i;
      aud_q2 <= aud_q1;
      aud_q3 <= aud_q2;
    end
  end

  assign aud_rise = aud_q2 & ~aud_q3;

  // Control register, write-only
  always @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_en  <= `SSAT_CTRL_EN_RST;
      ctrl_irq <= `SSAT_CTRL_IRQ_RST;
    end else if (ce_i && bus_wr_i && sel(bus_addr_i, `SSAT_OFF_CONTROL)) begin
      ctrl_en  <= bus_wdata_i[`SSAT_CTRL_EN_BIT];
      ctrl_irq <= bus_wdata_i[`SSAT_CTRL_IRQ_BIT];
    end
  end

  // full drops write
  // Partial-lane writes are ignored rather than storing half a frame
  assign st_wr_valid = bus_wr_i & sel(bus_addr_i, `SSAT_OFF_SAMPLE) &
                       (bus_be_i == `SSAT_FULL_BE);

  ssat_fifo u_store (
    .clk_i      (clk_i),
    .rst_n_i    (rst_n),
    .ce_i       (ce_i),
    .wr_valid_i (st_wr_valid),
    .wr_data_i  (bus_wdata_i),
    .wr_ready_o (),
    .rd_valid_o (st_rd_valid),
    .rd_data_o  (st_rd_data),
    .rd_ready_i (st_rd_ready),
    .level_o    (st_level)
  );

  assign fifo_low_status = (st_level < `SSAT_LOW_MARK);

  assign bit_end  = ctrl_en & aud_rise & (div_cnt == `SSAT_DIV_LAST);
  assign next_bit = bit_cnt + 5'h01;
  // Pop once per frame, at the last bit boundary
  assign st_rd_ready = bit_end & (bit_cnt == `SSAT_BIT_LAST);

  // Next shift word: new frame from the store, silence on underrun
  always @* begin
    next_shift = {shift[30:0], 1'b0};
    if (bit_cnt == `SSAT_BIT_LAST) begin
      next_shift = st_rd_valid ? st_rd_data : `SSAT_WORD_RST;
    end
  end

  // Serial engine; data and select change as the bit clock falls
  always @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      div_cnt               <= 3'h0;
      bit_cnt               <= `SSAT_BIT_LAST;
      shift                 <= `SSAT_WORD_RST;
      sck_o                 <= 1'b0;
      channel_select_line_o <= 1'b0;
    end else if (ce_i) begin
      if (!ctrl_en) begin
        div_cnt               <= 3'h0;
        bit_cnt               <= `SSAT_BIT_LAST;
        shift                 <= `SSAT_WORD_RST;
        sck_o                 <= 1'b0;
        channel_select_line_o <= 1'b0;
      end else if (aud_rise) begin
        div_cnt <= div_cnt + 3'h1;
        if (div_cnt == `SSAT_DIV_RISE) begin
          sck_o <= 1'b1;
        end
        if (bit_end) begin
          sck_o   <= 1'b0;
          bit_cnt <= next_bit;
          shift   <= next_shift;
          channel_select_line_o <= next_bit[4];
        end
      end
    end
  end

  assign sd_o = shift[31];

  assign rd_cause = bus_rd_i & sel(bus_addr_i, `SSAT_OFF_CAUSE);
  assign low_rise = fifo_low_status & ~low_q & ctrl_irq;

  // Pending request; a new event beats a clearing read
  always @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      low_q <= 1'b0;
      irq_o <= 1'b0;
    end else if (ce_i) begin
      low_q <= fifo_low_status;
      if (low_rise) begin
        irq_o <= 1'b1;
      end else if (rd_cause) begin
        irq_o <= 1'b0;
      end
    end
  end

  // Read data one cycle after the strobe; write-only words read zero
  always @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      bus_rdata_o  <= `SSAT_WORD_RST;
      bus_rvalid_o <= 1'b0;
    end else if (ce_i) begin
      bus_rvalid_o <= bus_rd_i;
      bus_rdata_o  <= `SSAT_WORD_RST;
      if (bus_rd_i && sel(bus_addr_i, `SSAT_OFF_STATUS)) begin
        bus_rdata_o[`SSAT_STAT_LOW_BIT] <= fifo_low_status;
      end
      if (rd_cause) begin
        bus_rdata_o[`SSAT_CAUSE_LOW_BIT] <= irq_o;
      end
    end
  end

endmodule // ssat_top

`default_nettype wire

// ==== sim/ssat_asserts.sv ====
`default_nettype none
module ssat_asserts (
  input wire logic clk_i, rst_n_i, ce_i, bus_wr_i, bus_rd_i, bus_rvalid_o,
  input wire logic aud_clk_i, sck_o, sd_o, channel_select_line_o, irq_o,
  input wire logic [3:0] bus_addr_i, bus_be_i,
  input wire logic [31:0] bus_wdata_i, bus_rdata_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  logic rd;
  int gap = 0;
  assign rd = bus_rd_i && ce_i;
  // Cycles since last bit clock rise; 0 once a gap is too long to judge
  always_ff @(posedge clk_i) begin
    if ($rose(sck_o)) gap <= 1;
    else if (gap != 0 && gap < 120) gap <= gap + 1;
    else gap <= 0;
  end
  property p_rv; rd |=> bus_rvalid_o; endproperty
  a_rv: assert property (p_rv) else $error("read not answered");
  property p_rvx; !rd |=> !bus_rvalid_o && bus_rdata_o == 0; endproperty
  a_rvx: assert property (p_rvx) else $error("stray read data");
  property p_wo; rd && bus_addr_i < 4'h8 |=> bus_rdata_o == 0; endproperty
  a_wo: assert property (p_wo) else $error("write-only reads back");
  property p_st; rd && bus_addr_i == 4'h8 |=> bus_rdata_o[31:1] == 0; endproperty
  a_st: assert property (p_st) else $error("status upper bits set");
  property p_sd; $rose(sck_o) |-> $stable(sd_o) && $stable(channel_select_line_o); endproperty
  a_sd: assert property (p_sd) else $error("data moves at clock rise");
  property p_ws; $changed(channel_select_line_o) |-> !sck_o; endproperty
  a_ws: assert property (p_ws) else $error("select moves with clock high");
  // Bit period is eight audio clocks, about 100 system cycles
  property p_per; $rose(sck_o) |-> gap == 0 || gap inside {[96:104]}; endproperty
  a_per: assert property (p_per) else $error("bit period wrong");
  property p_irq; irq_o && !(rd && bus_addr_i == 4'hC) |=> irq_o; endproperty
  a_irq: assert property (p_irq) else $error("request lost");
  property p_clr; irq_o && rd && bus_addr_i == 4'hC |=> bus_rdata_o[0]; endproperty
  a_clr: assert property (p_clr) else $error("cause not reported");
  c_irq: cover property ($rose(irq_o));
  c_ws: cover property ($rose(channel_select_line_o));
  c_cause: cover property (rd && bus_addr_i == 4'hC);
endmodule // ssat_asserts
bind ssat_top ssat_asserts u_ssat_asserts (.clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(ce_i),
  .bus_wr_i(bus_wr_i), .bus_rd_i(bus_rd_i), .bus_rvalid_o(bus_rvalid_o), .aud_clk_i(aud_clk_i),
  .sck_o(sck_o), .sd_o(sd_o), .channel_select_line_o(channel_select_line_o), .irq_o(irq_o),
  .bus_addr_i(bus_addr_i), .bus_be_i(bus_be_i), .bus_wdata_i(bus_wdata_i),
  .bus_rdata_o(bus_rdata_o));
`default_nettype wire

// ==== sim/ssat_dac_model.sv ====
`default_nettype none
module ssat_dac_model (
  output logic aud_clk_o,
  input wire logic sck_i,
  input wire logic sd_i,
  input wire logic ws_i,
  output logic [31:0] word_o,
  output int frames_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] sh = 0;
  int nr = 0;
  initial aud_clk_o = 0;
  initial word_o = 0;
  initial frames_o = 0;
  always #62.5 aud_clk_o = !aud_clk_o;
  // sample at rise; word ends after 16 right bits
  always @(posedge sck_i) begin
    sh = {sh[30:0], sd_i};
    nr = ws_i ? nr + 1 : 0;
    if (nr == 16) begin
      word_o = sh;
      frames_o = frames_o + 1;
    end
  end
endmodule // ssat_dac_model
`default_nettype wire

// ==== sim/testbench.sv ====
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 0, rst_n_i = 0, bus_wr_i = 0, bus_rd_i = 0, act, rv, ce = 1;
  logic [3:0] bus_addr_i = 0, be = 4'hF;
  logic [31:0] bus_wdata_i = 0, rdata;
  wire [31:0] bus_rdata_o, word;
  wire bus_rvalid_o, aud_clk, sck_o, sd_o, ws, irq_o;
  int err_total = 0, n_checks = 0, cyc = 0, frames, f;
  always #5 clk_i = !clk_i;
  // Byte enables and clock enable driven so refusal and freezing can be seen
  ssat_top u_ssat_top (.clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(ce), .bus_addr_i(bus_addr_i),
    .bus_wr_i(bus_wr_i), .bus_rd_i(bus_rd_i), .bus_be_i(be), .bus_wdata_i(bus_wdata_i),
    .bus_rdata_o(bus_rdata_o), .bus_rvalid_o(bus_rvalid_o), .aud_clk_i(aud_clk),
    .sck_o(sck_o), .sd_o(sd_o), .channel_select_line_o(ws), .irq_o(irq_o));
  ssat_dac_model u_ssat_dac_model (.aud_clk_o(aud_clk), .sck_i(sck_o), .sd_i(sd_o),
    .ws_i(ws), .word_o(word), .frames_o(frames));
  function automatic logic [31:0] smp(int i);
    return {16'hA5C3 ^ i[15:0], 16'h3C5A + i[15:0]};
  endfunction
  task automatic chk(input logic [31:0] got, exp);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_i);
    bus_wr_i <= 1;
    bus_addr_i <= a;
    bus_wdata_i <= d;
    @(posedge clk_i);
    bus_wr_i <= 0;
  endtask
  // Read data is sampled mid-cycle, after the answer edge settles
  task automatic rd(input logic [3:0] a);
    @(posedge clk_i);
    bus_rd_i <= 1;
    bus_addr_i <= a;
    @(posedge clk_i);
    bus_rd_i <= 0;
    @(negedge clk_i);
    rdata = bus_rdata_o;
    rv = bus_rvalid_o;
  endtask
  // A wait that runs out counts as a mismatch
  task automatic wfr(int n);
    for (int i = 0; i < 4000 && frames < n; i++) @(posedge clk_i);
    if (frames < n) begin
      err_total++;
      $display("[ERR] %0t frame wait ran out", $time);
    end
  endtask
  task automatic t_idle();
    rd(4'h8);
    chk(rdata, 32'h1);
    chk({31'h0, rv}, 32'h1);
    rd(4'h0);
    chk(rdata, 32'h0);
    rd(4'h2);
    chk(rdata, 32'h0);
  endtask
  // Low flag boundary at 127 and 128 stored words
  task automatic t_fill();
    for (int i = 0; i < 127; i++) wr(4'h0, smp(i));
    rd(4'h8);
    chk(rdata, 32'h1);
    wr(4'h0, smp(127));
    rd(4'h8);
    chk(rdata, 32'h0);
  endtask
  task automatic t_off();
    act = 0;
    wr(4'h4, 32'h2);
    for (int i = 0; i < 300; i++) @(posedge clk_i) act |= (sck_o | sd_o | ws | irq_o) !== 0;
    chk({31'h0, act}, 32'h0);
  endtask
  // First pop takes the store below the mark and raises the request
  task automatic t_stream();
    wr(4'h4, 32'h3);
    wfr(1);
    chk(word, smp(0));
    chk({31'h0, irq_o}, 32'h1);
    rd(4'hC);
    chk(rdata, 32'h1);
    chk({31'h0, irq_o}, 32'h0);
    wfr(2);
    chk(word, smp(1));
  endtask
  // Disable in the right half of a frame; link must go quiet
  task automatic t_abort();
    for (int i = 0; i < 400 && ws !== 1; i++) @(posedge clk_i);
    wr(4'h4, 32'h0);
    repeat (3) @(posedge clk_i);
    chk({29'h0, sck_o, sd_o, ws}, 32'h0);
    f = frames;
    repeat (4000) @(posedge clk_i);
    chk(frames, f);
  endtask
  // Frozen enable, then fill to the brim; the overflow write would hit the next slot out
  task automatic t_full();
    ce <= 0;
    wr(4'h0, 32'hFFFF_FFFF);
    ce <= 1;
    @(posedge clk_i);
    chk({23'h0, u_ssat_top.u_store.level_o}, 32'h0000_007E);
    for (int i = 128; i < 257; i++) wr(4'h0, smp(i));
    be <= 4'h3;
    wr(4'h0, 32'hFFFF_FFFF);
    be <= 4'hF;
    @(posedge clk_i);
    chk({23'h0, u_ssat_top.u_store.level_o}, 32'h0000_00FF);
    wr(4'h0, smp(257));
    wr(4'h0, 32'hFFFF_FFFF);
    @(posedge clk_i);
    chk({23'h0, u_ssat_top.u_store.level_o}, 32'h0000_0100);
    rd(4'h8);
    chk(rdata, 32'h0);
    wr(4'h4, 32'h1);
    wfr(3);
    chk(word, smp(2));
  endtask
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // Hang guard
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 30000) begin
      err_total++;
      tally_and_finish();
    end
  end
  initial begin
    repeat (5) @(posedge clk_i);
    rst_n_i <= 1;
    repeat (3) @(posedge clk_i);
    t_idle();
    t_fill();
    t_off();
    t_stream();
    t_abort();
    t_full();
    tally_and_finish();
  end
endmodule // testbench
`default_nettype wire
